//--- design/srw_pkg.sv
/*
  Package of constants for the supervisory reset and watchdog block.
  Assumes a single 20 MHz clock; no software registers exist.
*/
package srw_pkg;
  localparam int unsigned CLOCK_HZ             = 20000000;
  localparam int unsigned CLOCK_NS             = 50;
  // Hold period in microseconds (default 140 ms) and watchdog period (default 102 ms).
  localparam int unsigned RESET_HOLD_PERIOD_US = 140000;
  localparam int unsigned WATCHDOG_PERIOD_US   = 102000;
  localparam int unsigned RESET_HOLD_CYCLES    =
    32'((RESET_HOLD_PERIOD_US * 64'd1000 + CLOCK_NS - 1) / CLOCK_NS);
  localparam int unsigned WATCHDOG_CYCLES      =
    32'((WATCHDOG_PERIOD_US * 64'd1000) / CLOCK_NS);
  localparam int unsigned FLOAT_NUM            = 7;
  localparam int unsigned FLOAT_DEN            = 8;
  localparam int unsigned COUNT_W              = 32;
  localparam logic        RESET_ASSERTED_LOW   = 1'b0;
  typedef enum logic [0:0] {
    SRW_RUN  = 1'b0,
    SRW_HOLD = 1'b1
  } srw_state_t;
endpackage

//--- design/srw_sync.sv
/*
  Two-flip-flop synchroniser for one asynchronous pin.
  Assumes the pin is unrelated to clock; reset value is a parameter.
*/
module srw_sync #(
  parameter logic INIT = 1'b1
) (
  // Clock and reset.
  input  wire logic clock,
  input  wire logic rst,
  // Pin in, synchronised level out.
  input  wire logic pin,
  output logic      level
);
  logic stage1;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage1 <= INIT;
      level  <= INIT;
    end else begin
      stage1 <= pin;
      level  <= stage1;
    end
  end
endmodule

//--- design/srw_counter.sv
/*
  Up counter with clear and terminal flag, used for hold and watchdog timing.
  Assumes terminal is at least one.
*/
module srw_counter #(
  parameter int unsigned W = 32
) (
  // Clock and reset.
  input  wire logic         clock,
  input  wire logic         rst,
  // Control.
  input  wire logic         clear,
  input  wire logic [W-1:0] terminal,
  // Status.
  output logic              done
);
  logic [W-1:0] count;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (count != terminal) begin
      count <= count + 1'b1;
    end
  end

  assign done = !clear && (count == terminal);
endmodule

//--- design/srw_top.sv
/*
  Supervisory reset generator with manual reset and watchdog.
  Assumes the supply comparator and float detector arrive as pins, which are
  synchronised here; the processor receives the reset outputs.
*/
module srw_top #(
  parameter int unsigned RESET_HOLD_CYCLES = srw_pkg::RESET_HOLD_CYCLES,
  parameter int unsigned WATCHDOG_CYCLES   = srw_pkg::WATCHDOG_CYCLES
) (
  // Clock and reset.
  input  wire logic clock,
  input  wire logic rst,
  // Supervised conditions.
  input  wire logic supply_low,
  input  wire logic manual_reset_n,
  input  wire logic watchdog_kick_in,
  input  wire logic watchdog_kick_float,
  // Reset outputs.
  output logic      reset_out_n,
  output logic      reset_out,
  output logic      reset_od_out,
  output logic      reset_od_oe
);
  localparam int unsigned FLOAT_CYCLES =
    (WATCHDOG_CYCLES * srw_pkg::FLOAT_NUM) / srw_pkg::FLOAT_DEN;
  localparam logic [srw_pkg::COUNT_W-1:0] HOLD_TERM =
    srw_pkg::COUNT_W'(RESET_HOLD_CYCLES - 1);
  localparam logic [srw_pkg::COUNT_W-1:0] WD_TERM =
    srw_pkg::COUNT_W'(WATCHDOG_CYCLES - 1);

  logic              supply_low_s;
  logic              manual_n_s;
  logic              kick_s;
  logic              float_s;
  logic              kick_prev;
  logic              kick_edge;
  logic              cause;
  logic              wd_clear;
  logic              wd_done;
  logic              hold_clear;
  logic              hold_done;
  logic [31:0]       float_count;
  logic              float_tick;
  srw_pkg::srw_state_t state;

  // Every asynchronous input passes two flip-flops before use.
  srw_sync #(.INIT(1'b1)) u_sync_supply (
    .clock (clock),
    .rst   (rst),
    .pin   (supply_low),
    .level (supply_low_s)
  );
  srw_sync #(.INIT(1'b1)) u_sync_manual (
    .clock (clock),
    .rst   (rst),
    .pin   (manual_reset_n),
    .level (manual_n_s)
  );
  srw_sync #(.INIT(1'b0)) u_sync_kick (
    .clock (clock),
    .rst   (rst),
    .pin   (watchdog_kick_in),
    .level (kick_s)
  );
  srw_sync #(.INIT(1'b0)) u_sync_float (
    .clock (clock),
    .rst   (rst),
    .pin   (watchdog_kick_float),
    .level (float_s)
  );

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      kick_prev <= 1'b0;
    end else begin
      kick_prev <= kick_s;
    end
  end
  assign kick_edge = kick_s ^ kick_prev;

  // A floating kick input is serviced internally at seven eighths of the period.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      float_count <= '0;
    end else if (!float_s || float_tick || state == srw_pkg::SRW_HOLD) begin
      float_count <= '0;
    end else begin
      float_count <= float_count + 32'h0000_0001;
    end
  end
  assign float_tick = float_s && (float_count == 32'(FLOAT_CYCLES - 1));

  // Watchdog expiry counts only while reset is released.
  // A floating input also clears it when service starts, so no stale count can expire.
  assign wd_clear = (state == srw_pkg::SRW_HOLD) || kick_edge || float_tick ||
                    (float_s && (float_count == 32'h0000_0000));

  srw_counter #(.W(srw_pkg::COUNT_W)) u_wd_count (
    .clock    (clock),
    .rst      (rst),
    .clear    (wd_clear),
    .terminal (WD_TERM),
    .done     (wd_done)
  );

  assign cause = supply_low_s || !manual_n_s || wd_done;

  // The hold period restarts while any cause is present.
  assign hold_clear = cause || (state == srw_pkg::SRW_RUN);

  srw_counter #(.W(srw_pkg::COUNT_W)) u_hold_count (
    .clock    (clock),
    .rst      (rst),
    .clear    (hold_clear),
    .terminal (HOLD_TERM),
    .done     (hold_done)
  );

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= srw_pkg::SRW_HOLD;
    end else begin
      case (state)
        srw_pkg::SRW_RUN: begin
          if (cause) begin
            state <= srw_pkg::SRW_HOLD;
          end
        end
        srw_pkg::SRW_HOLD: begin
          if (hold_done) begin
            state <= srw_pkg::SRW_RUN;
          end
        end
        default: begin
          state <= srw_pkg::SRW_HOLD;
        end
      endcase
    end
  end

  // All reset outputs are registered and asserted from reset onward.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reset_out_n  <= srw_pkg::RESET_ASSERTED_LOW;
      reset_out    <= 1'b1;
      reset_od_oe  <= 1'b1;
      reset_od_out <= 1'b0;
    end else begin
      reset_out_n  <= (state == srw_pkg::SRW_RUN) && !cause;
      reset_out    <= !((state == srw_pkg::SRW_RUN) && !cause);
      reset_od_oe  <= !((state == srw_pkg::SRW_RUN) && !cause);
      reset_od_out <= 1'b0;
    end
  end

  // Helper: cycles spent in hold since the last cause.
  logic [31:0] hold_len;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hold_len <= '0;
    end else if (state == srw_pkg::SRW_RUN || cause) begin
      hold_len <= '0;
    end else begin
      hold_len <= hold_len + 32'h0000_0001;
    end
  end

  property p_supply;
    @(posedge clock) disable iff (rst) supply_low_s |=> !reset_out_n;
  endproperty
  a_supply: assert property (p_supply) else $error("supply low without reset");

  property p_manual;
    @(posedge clock) disable iff (rst) !manual_n_s |=> reset_out;
  endproperty
  a_manual: assert property (p_manual) else $error("manual reset ignored");

  property p_hold;
    @(posedge clock) disable iff (rst)
      $rose(reset_out_n) |-> $past(hold_len) == 32'(RESET_HOLD_CYCLES);
  endproperty
  a_hold: assert property (p_hold) else $error("hold period wrong");

  property p_inverse;
    @(posedge clock) disable iff (rst) reset_out == !reset_out_n;
  endproperty
  a_inverse: assert property (p_inverse) else $error("outputs not inverse");

  property p_od;
    @(posedge clock) disable iff (rst) !reset_od_out && (reset_od_oe == !reset_out_n);
  endproperty
  a_od: assert property (p_od) else $error("open drain drives high");

  property p_wd_expire;
    @(posedge clock) disable iff (rst) wd_done |=> !reset_out_n;
  endproperty
  a_wd_expire: assert property (p_wd_expire) else $error("watchdog expiry no reset");

  property p_wd_held;
    @(posedge clock) disable iff (rst) (state == srw_pkg::SRW_HOLD) |-> !wd_done;
  endproperty
  a_wd_held: assert property (p_wd_held) else $error("watchdog ran during reset");

  property p_release;
    @(posedge clock) disable iff (rst) hold_done |=> state == srw_pkg::SRW_RUN;
  endproperty
  a_release: assert property (p_release) else $error("no release at hold end");

  property p_edge;
    @(posedge clock) disable iff (rst) kick_edge |-> !wd_done;
  endproperty
  a_edge: assert property (p_edge) else $error("edge did not clear watchdog");

  property p_restart;
    @(posedge clock) disable iff (rst) cause && !reset_out_n |=> hold_len == 32'h0;
  endproperty
  a_restart: assert property (p_restart) else $error("hold not restarted");

  // Helper: cycles in run without a kick edge or a floating input.
  logic [31:0] kick_idle;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      kick_idle <= '0;
    end else if (state == srw_pkg::SRW_HOLD || kick_edge || float_s) begin
      kick_idle <= '0;
    end else begin
      kick_idle <= kick_idle + 32'h0000_0001;
    end
  end

  property p_supply_oe;
    @(posedge clock) disable iff (rst) supply_low_s |=> reset_od_oe && reset_out;
  endproperty
  a_supply_oe: assert property (p_supply_oe) else $error("supply low not driven");

  property p_cause_hold;
    @(posedge clock) disable iff (rst) cause |=> (state == srw_pkg::SRW_HOLD);
  endproperty
  a_cause_hold: assert property (p_cause_hold) else $error("cause did not hold");

  property p_out_release;
    @(posedge clock) disable iff (rst) (state == srw_pkg::SRW_RUN) && !cause |=> reset_out_n;
  endproperty
  a_out_release: assert property (p_out_release) else $error("reset not released");

  property p_wd_zero;
    @(posedge clock) disable iff (rst)
      (state == srw_pkg::SRW_HOLD) |=> (u_wd_count.count == 32'h0000_0000);
  endproperty
  a_wd_zero: assert property (p_wd_zero) else $error("watchdog not held clear");

  property p_wd_on_assert;
    @(posedge clock) disable iff (rst)
      $fell(reset_out_n) |=> (u_wd_count.count == 32'h0000_0000);
  endproperty
  a_wd_on_assert: assert property (p_wd_on_assert) else $error("watchdog kept count");

  property p_wd_from_zero;
    @(posedge clock) disable iff (rst)
      $rose(state == srw_pkg::SRW_RUN) |-> (u_wd_count.count == 32'h0000_0000);
  endproperty
  a_wd_from_zero: assert property (p_wd_from_zero) else $error("watchdog not from zero");

  property p_wd_step;
    @(posedge clock) disable iff (rst)
      !wd_clear && (u_wd_count.count != WD_TERM) |=>
        (u_wd_count.count == $past(u_wd_count.count) + 32'h0000_0001);
  endproperty
  a_wd_step: assert property (p_wd_step) else $error("watchdog did not count");

  property p_kick_stuck;
    @(posedge clock) disable iff (rst) kick_idle <= 32'(WATCHDOG_CYCLES);
  endproperty
  a_kick_stuck: assert property (p_kick_stuck) else $error("stuck kick not caught");

  property p_kick_clear;
    @(posedge clock) disable iff (rst) kick_edge |=> (u_wd_count.count == 32'h0000_0000);
  endproperty
  a_kick_clear: assert property (p_kick_clear) else $error("kick edge kept count");

  property p_float_tick;
    @(posedge clock) disable iff (rst) float_tick |=> (u_wd_count.count == 32'h0000_0000);
  endproperty
  a_float_tick: assert property (p_float_tick) else $error("float service kept count");

  property p_float_quiet;
    @(posedge clock) disable iff (rst) float_s |-> !wd_done;
  endproperty
  a_float_quiet: assert property (p_float_quiet) else $error("floating kick expired");

  property p_hold_start;
    @(posedge clock) disable iff (rst)
      (state == srw_pkg::SRW_HOLD) && !cause && $past(cause) |->
        (u_hold_count.count == 32'h0000_0000);
  endproperty
  a_hold_start: assert property (p_hold_start) else $error("hold not from zero");

  property p_hold_step;
    @(posedge clock) disable iff (rst)
      (state == srw_pkg::SRW_HOLD) && !cause && !hold_done |=>
        (u_hold_count.count == $past(u_hold_count.count) + 32'h0000_0001);
  endproperty
  a_hold_step: assert property (p_hold_step) else $error("hold did not count");

  property p_sync_supply;
    @(posedge clock) disable iff (rst)
      !$past(rst, 2) |-> (supply_low_s == $past(supply_low, 2));
  endproperty
  a_sync_supply: assert property (p_sync_supply) else $error("supply sync delay wrong");

  property p_sync_manual;
    @(posedge clock) disable iff (rst)
      !$past(rst, 2) |-> (manual_n_s == $past(manual_reset_n, 2));
  endproperty
  a_sync_manual: assert property (p_sync_manual) else $error("manual sync delay wrong");

  property p_sync_kick;
    @(posedge clock) disable iff (rst)
      !$past(rst, 2) |-> (kick_s == $past(watchdog_kick_in, 2));
  endproperty
  a_sync_kick: assert property (p_sync_kick) else $error("kick sync delay wrong");
endmodule

//--- tb/srw_cpu_model.sv
/*
  Processor-side model: kicks the watchdog and sees the reset line.
  Assumes the bench supplies the clock and the resolved reset line.
*/
module srw_cpu_model #(
  parameter int unsigned GAP = 10
) (
  // Clock and reset line seen by the processor.
  input  wire logic clock,
  input  wire logic reset_n,
  // Bench commands.
  input  wire logic kick_on,
  input  wire logic float_on,
  // Watchdog pin and its float indication.
  output logic      kick,
  output logic      kick_float
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned gap_count = 0;
  initial kick = 1'b0;
  initial kick_float = 1'b0;
  // A released pin flips once to the inverse of its last level and then holds.
  // On reattach the driver kicks at once, so the float service gap cannot expire.
  always @(posedge clock) begin
    kick_float <= float_on;
    if (float_on) begin
      if (!kick_float) begin
        kick <= ~kick;
      end
      gap_count <= GAP;
    end else if (kick_on && reset_n && gap_count >= GAP) begin
      kick      <= ~kick;
      gap_count <= 0;
    end else begin
      gap_count <= gap_count + 1;
    end
  end
endmodule

//--- tb/supervisor_reset_watchdog_test.sv
/*
  Self-checking bench for the reset supervisor with watchdog.
  Assumes short hold and watchdog counts and a pulled-up open-drain line.
*/
module supervisor_reset_watchdog_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HOLD = 20;
  localparam int WD   = 40;
  logic clock = 1'b0;
  logic rst, supply_low, manual_reset_n, kick, kick_float, kick_on, float_on;
  logic reset_out_n, reset_out, reset_od_out, reset_od_oe, reset_line;
  int   err_total = 0;
  int   n_checks = 0;
  int   cycles = 0;
  int   n;
  assign reset_line = reset_od_oe ? reset_od_out : 1'b1;
  srw_top #(.RESET_HOLD_CYCLES(HOLD), .WATCHDOG_CYCLES(WD)) uut (
    .clock(clock), .rst(rst), .supply_low(supply_low), .manual_reset_n(manual_reset_n),
    .watchdog_kick_in(kick), .watchdog_kick_float(kick_float), .reset_out_n(reset_out_n),
    .reset_out(reset_out), .reset_od_out(reset_od_out), .reset_od_oe(reset_od_oe));
  srw_cpu_model cpu (.clock(clock), .reset_n(reset_line), .kick_on(kick_on),
    .float_on(float_on), .kick(kick), .kick_float(kick_float));
  always #25 clock = ~clock;
  task end_of_test;
    if (err_total == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %b seen %b", what, exp, got);
    end
  endtask
  task chk_range(input string what, input int lo, input int hi, input int got);
    n_checks++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("unexpected %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task wait_level(input logic val, input int max, output int cnt);
    cnt = 0;
    while (reset_out_n !== val && cnt < max) begin
      @(posedge clock);
      #1;
      cnt++;
    end
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      end_of_test();
    end
  end
  always @(negedge clock) begin
    if (!rst) begin
      chk_bit("reset_out", ~reset_out_n, reset_out);
      chk_bit("reset_od_out", 1'b0, reset_od_out);
      chk_bit("reset_od_oe", ~reset_out_n, reset_od_oe);
    end
  end
  task t_power_up;
    chk_bit("reset after rst", 1'b0, reset_out_n);
    wait_level(1'b1, HOLD + 10, n);
    chk_range("power-up hold", HOLD, HOLD + 6, n);
  endtask
  task t_cause(input bit manual);
    @(posedge clock);
    if (manual) manual_reset_n <= 1'b0;
    else supply_low <= 1'b1;
    wait_level(1'b0, 6, n);
    chk_range("cause to reset", 1, 5, n);
    repeat (5) @(posedge clock);
    manual_reset_n <= 1'b1;
    supply_low     <= 1'b0;
    wait_level(1'b1, HOLD + 10, n);
    chk_range("cause hold", HOLD, HOLD + 6, n);
  endtask
  task t_kicked;
    wait_level(1'b0, 4 * WD, n);
    chk_range("kicked run", 4 * WD, 4 * WD, n);
  endtask
  task t_starved;
    @(posedge clock);
    kick_on <= 1'b0;
    wait_level(1'b0, WD + 10, n);
    chk_range("watchdog expiry", WD - 12, WD + 6, n);
    wait_level(1'b1, HOLD + 10, n);
    chk_range("watchdog hold", HOLD - 1, HOLD + 6, n);
    wait_level(1'b0, WD + 10, n);
    chk_range("restart from zero", WD - 1, WD + 5, n);
    @(posedge clock);
    kick_on <= 1'b1;
    wait_level(1'b1, HOLD + 10, n);
    chk_range("repeat watchdog hold", HOLD - 1, HOLD + 6, n);
  endtask
  task t_float;
    @(posedge clock);
    float_on <= 1'b1;
    wait_level(1'b0, 4 * WD, n);
    chk_range("floating kick run", 4 * WD, 4 * WD, n);
    @(posedge clock);
    float_on <= 1'b0;
  endtask
  task t_restart;
    @(posedge clock);
    manual_reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    manual_reset_n <= 1'b1;
    repeat (10) @(posedge clock);
    supply_low <= 1'b1;
    repeat (2) @(posedge clock);
    supply_low <= 1'b0;
    #1;
    chk_bit("reset during restart", 1'b0, reset_out_n);
    wait_level(1'b1, HOLD + 10, n);
    chk_range("restarted hold", HOLD, HOLD + 6, n);
  endtask
  initial begin
    rst            = 1'b1;
    supply_low     = 1'b0;
    manual_reset_n = 1'b1;
    kick_on        = 1'b1;
    float_on       = 1'b0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    t_power_up();
    t_cause(1'b0);
    t_cause(1'b1);
    t_kicked();
    t_starved();
    t_float();
    t_restart();
    end_of_test();
  end
endmodule
